// *** jnpp_regs.vh ***
// constants for the nvm programming test port
`ifndef JNPP_REGS_VH
`define JNPP_REGS_VH
// instruction codes
`define JNPP_IR_W 4
`define JNPP_IR_CORE_HOLD 4'hC
`define JNPP_IR_UNLOCK 4'h4
`define JNPP_IR_CMD 4'h5
`define JNPP_IR_FILL 4'h6
`define JNPP_IR_DUMP 4'h7
`define JNPP_IR_BYPASS 4'hF
// data register widths
`define JNPP_UNLOCK_W 16
`define JNPP_CMD_W 15
`define JNPP_UNLOCK_SIG 16'hA370
`define JNPP_UNLOCK_RST 16'h0000
`define JNPP_CMD_RST 15'h0000
// page geometry: 128 bytes of 8 bits
`define JNPP_PAGE_BYTES 128
`define JNPP_PAGE_AW 7
// tap-disable release delay in chip clocks
`define JNPP_TD_CLR_CYC 2
// reset time-out default in chip clocks
`define JNPP_RST_TO_CYC 64
`define JNPP_RST_TO_W 16
// tap states, one-hot
`define JNPP_ST_W 16
`define JNPP_S_TLR 16'h0001
`define JNPP_S_RTI 16'h0002
`define JNPP_S_SDRS 16'h0004
`define JNPP_S_CDR 16'h0008
`define JNPP_S_SDR 16'h0010
`define JNPP_S_E1DR 16'h0020
`define JNPP_S_PDR 16'h0040
`define JNPP_S_E2DR 16'h0080
`define JNPP_S_UDR 16'h0100
`define JNPP_S_SIRS 16'h0200
`define JNPP_S_CIR 16'h0400
`define JNPP_S_SIR 16'h0800
`define JNPP_S_E1IR 16'h1000
`define JNPP_S_PIR 16'h2000
`define JNPP_S_E2IR 16'h4000
`define JNPP_S_UIR 16'h8000
`endif

// *** jnpp_sync.v ***
// two flip-flop synchroniser for one pin
`timescale 1ns/1ps
module jnpp_sync (
    input wire i_mclk,
    input wire i_rst,
    input wire i_d,
    output reg o_q
);
    reg meta_q;
    // --------------------------------
    // first stage is read only by the second
    // --------------------------------
    always @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            meta_q <= 1'b0;
            o_q <= 1'b0;
        end else begin
            meta_q <= i_d;
            o_q <= meta_q;
        end
    end
endmodule

// *** jnpp_port.v ***
// nvm programming test access port, clocked by the chip clock
`timescale 1ns/1ps
`include "jnpp_regs.vh"
module jnpp_port (
    input wire i_mclk,
    input wire i_rst,
    input wire i_tck,
    input wire i_tms,
    input wire i_tdi,
    input wire i_tap_access_fuse,
    input wire i_tap_disable_set,
    input wire i_ext_reset_n,
    input wire [`JNPP_CMD_W-1:0] i_cmd_result,
    input wire [7:0] i_page_rdata,
    output reg o_tdo,
    output reg o_tdo_oe,
    output reg o_tap_disable_bit,
    output reg o_core_reset,
    output reg o_prog_enabled,
    output reg [`JNPP_CMD_W-1:0] o_cmd,
    output reg o_cmd_valid,
    output reg o_cmd_exec,
    output reg o_page_we,
    output reg [`JNPP_PAGE_AW-1:0] o_page_addr,
    output reg [7:0] o_page_wdata,
    output reg o_page_re
);
    // --------------------------------
    // pin synchronisers
    // --------------------------------
    wire tck_s, tms_s, tdi_s, xrst_n_s;
    jnpp_sync u_s_tck (.i_mclk(i_mclk), .i_rst(i_rst), .i_d(i_tck), .o_q(tck_s));
    jnpp_sync u_s_tms (.i_mclk(i_mclk), .i_rst(i_rst), .i_d(i_tms), .o_q(tms_s));
    jnpp_sync u_s_tdi (.i_mclk(i_mclk), .i_rst(i_rst), .i_d(i_tdi), .o_q(tdi_s));
    jnpp_sync u_s_xrst (.i_mclk(i_mclk), .i_rst(i_rst), .i_d(i_ext_reset_n),
        .o_q(xrst_n_s));

    reg tck_q;
    wire tck_rise = tck_s & ~tck_q;
    wire tck_fall = ~tck_s & tck_q;

    // --------------------------------
    // tap disable bit and port gate
    // --------------------------------
    reg [1:0] td_cnt_q;
    wire port_on = i_tap_access_fuse & ~o_tap_disable_bit;
    always @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_tap_disable_bit <= 1'b0;
            td_cnt_q <= 2'd0;
        end else begin
            if (i_tap_disable_set) begin
                o_tap_disable_bit <= 1'b1;
                td_cnt_q <= 2'd0;
            end else if (o_tap_disable_bit && !xrst_n_s) begin
                // count chip clocks with reset held low, then release the pins
                if (td_cnt_q == `JNPP_TD_CLR_CYC - 1) begin
                    o_tap_disable_bit <= 1'b0;
                    td_cnt_q <= 2'd0;
                end else begin
                    td_cnt_q <= td_cnt_q + 2'd1;
                end
            end else begin
                td_cnt_q <= 2'd0;
            end
        end
    end

    // --------------------------------
    // tap state machine
    // --------------------------------
    reg [`JNPP_ST_W-1:0] st_q, st_d;
    always @* begin
        st_d = st_q;
        case (st_q)
            `JNPP_S_TLR: st_d = tms_s ? `JNPP_S_TLR : `JNPP_S_RTI;
            `JNPP_S_RTI: st_d = tms_s ? `JNPP_S_SDRS : `JNPP_S_RTI;
            `JNPP_S_SDRS: st_d = tms_s ? `JNPP_S_SIRS : `JNPP_S_CDR;
            `JNPP_S_CDR: st_d = tms_s ? `JNPP_S_E1DR : `JNPP_S_SDR;
            `JNPP_S_SDR: st_d = tms_s ? `JNPP_S_E1DR : `JNPP_S_SDR;
            `JNPP_S_E1DR: st_d = tms_s ? `JNPP_S_UDR : `JNPP_S_PDR;
            `JNPP_S_PDR: st_d = tms_s ? `JNPP_S_E2DR : `JNPP_S_PDR;
            `JNPP_S_E2DR: st_d = tms_s ? `JNPP_S_UDR : `JNPP_S_SDR;
            `JNPP_S_UDR: st_d = tms_s ? `JNPP_S_SDRS : `JNPP_S_RTI;
            `JNPP_S_SIRS: st_d = tms_s ? `JNPP_S_TLR : `JNPP_S_CIR;
            `JNPP_S_CIR: st_d = tms_s ? `JNPP_S_E1IR : `JNPP_S_SIR;
            `JNPP_S_SIR: st_d = tms_s ? `JNPP_S_E1IR : `JNPP_S_SIR;
            `JNPP_S_E1IR: st_d = tms_s ? `JNPP_S_UIR : `JNPP_S_PIR;
            `JNPP_S_PIR: st_d = tms_s ? `JNPP_S_E2IR : `JNPP_S_PIR;
            `JNPP_S_E2IR: st_d = tms_s ? `JNPP_S_UIR : `JNPP_S_SIR;
            `JNPP_S_UIR: st_d = tms_s ? `JNPP_S_SDRS : `JNPP_S_RTI;
            default: st_d = `JNPP_S_TLR;
        endcase
    end

    // --------------------------------
    // shift registers and datapath
    // --------------------------------
    reg [`JNPP_IR_W-1:0] ir_sh_q, ir_q;
    reg hold_chain_q;
    reg [`JNPP_UNLOCK_W-1:0] unlock_q;
    reg [`JNPP_CMD_W-1:0] cmd_sh_q;
    reg [7:0] byte_sh_q;
    reg [2:0] bit_cnt_q;
    reg byp_q;
    reg cmd_pending_q;
    reg tdo_bit;

    wire sel_hold = (ir_q == `JNPP_IR_CORE_HOLD);
    wire sel_unlock = (ir_q == `JNPP_IR_UNLOCK);
    wire sel_cmd = (ir_q == `JNPP_IR_CMD);
    wire sel_fill = (ir_q == `JNPP_IR_FILL) & o_prog_enabled;
    wire sel_dump = (ir_q == `JNPP_IR_DUMP) & o_prog_enabled;
    wire adv = port_on & tck_rise;

    always @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            tck_q <= 1'b0;
            st_q <= `JNPP_S_TLR;
            ir_sh_q <= 4'h0;
            ir_q <= `JNPP_IR_BYPASS;
            hold_chain_q <= 1'b0;
            unlock_q <= `JNPP_UNLOCK_RST;
            o_prog_enabled <= 1'b0;
            cmd_sh_q <= `JNPP_CMD_RST;
            o_cmd <= `JNPP_CMD_RST;
            o_cmd_valid <= 1'b0;
            o_cmd_exec <= 1'b0;
            cmd_pending_q <= 1'b0;
            byte_sh_q <= 8'h00;
            bit_cnt_q <= 3'd0;
            byp_q <= 1'b0;
            o_page_we <= 1'b0;
            o_page_re <= 1'b0;
            o_page_addr <= 7'h00;
            o_page_wdata <= 8'h00;
        end else begin
            tck_q <= tck_s;
            o_cmd_exec <= 1'b0;
            o_cmd_valid <= 1'b0;
            o_page_we <= 1'b0;
            o_page_re <= 1'b0;
            if (adv) begin
                st_q <= st_d;
                // instruction register, lsb in first
                if (st_q == `JNPP_S_CIR)
                    ir_sh_q <= 4'h1;
                else if (st_q == `JNPP_S_SIR)
                    ir_sh_q <= {tdi_s, ir_sh_q[3:1]};
                if (st_q == `JNPP_S_UIR)
                    ir_q <= ir_sh_q;
                else if (st_q == `JNPP_S_TLR)
                    ir_q <= `JNPP_IR_BYPASS; // the hold chain survives this
                // shift-dr per selected register
                if (st_q == `JNPP_S_SDR) begin
                    if (sel_hold)
                        hold_chain_q <= tdi_s;
                    else if (sel_unlock)
                        unlock_q <= {tdi_s, unlock_q[15:1]};
                    else if (sel_cmd)
                        cmd_sh_q <= {tdi_s, cmd_sh_q[14:1]};
                    else if (sel_fill) begin
                        byte_sh_q <= {tdi_s, byte_sh_q[7:1]};
                        bit_cnt_q <= bit_cnt_q + 3'd1;
                        if (bit_cnt_q == 3'd7) begin
                            // full byte goes straight to the page buffer
                            o_page_wdata <= {tdi_s, byte_sh_q[7:1]};
                            o_page_we <= 1'b1;
                            o_page_addr <= o_page_addr + 7'd1;
                        end
                    end else if (sel_dump) begin
                        // tdi never enters the dump shifter
                        bit_cnt_q <= bit_cnt_q + 3'd1;
                        if (bit_cnt_q == 3'd7) begin
                            byte_sh_q <= i_page_rdata;
                            o_page_re <= 1'b1;
                            // step on so the next byte is prefetched well before its load
                            o_page_addr <= o_page_addr + 7'd1;
                        end else begin
                            byte_sh_q <= {1'b0, byte_sh_q[7:1]};
                        end
                    end else
                        byp_q <= tdi_s;
                end
                // capture-dr: the command register loads the result, fill and dump clear the byte shifter and page address
                if (st_q == `JNPP_S_CDR) begin
                    bit_cnt_q <= 3'd0;
                    if (sel_cmd)
                        cmd_sh_q <= i_cmd_result;
                    if (sel_fill || sel_dump) begin
                        o_page_addr <= 7'h00;
                        o_page_re <= sel_dump;
                        byte_sh_q <= 8'h00; // lead dummy byte shifts out as zeros
                    end
                    if (!sel_cmd)
                        byp_q <= 1'b0;
                end
                // update-dr
                if (st_q == `JNPP_S_UDR) begin
                    if (sel_unlock)
                        o_prog_enabled <= (unlock_q == `JNPP_UNLOCK_SIG);
                    if (sel_cmd && o_prog_enabled) begin
                        o_cmd <= cmd_sh_q;
                        o_cmd_valid <= 1'b1;
                        cmd_pending_q <= 1'b1;
                    end
                end
                // one execute clock on entering run-test/idle after an update
                // the arming update may itself be the step into idle
                if (st_d == `JNPP_S_RTI && st_q != `JNPP_S_RTI &&
                    (cmd_pending_q || (st_q == `JNPP_S_UDR && sel_cmd && o_prog_enabled))) begin
                    o_cmd_exec <= 1'b1;
                    cmd_pending_q <= 1'b0;
                end
            end
        end
    end

    // --------------------------------
    // tdo mux, lsb out first
    // --------------------------------
    always @* begin
        tdo_bit = byp_q;
        if (st_q == `JNPP_S_SIR)
            tdo_bit = ir_sh_q[0];
        else if (sel_hold)
            tdo_bit = hold_chain_q;
        else if (sel_unlock)
            tdo_bit = unlock_q[0];
        else if (sel_cmd)
            tdo_bit = cmd_sh_q[0];
        else if (sel_fill || sel_dump)
            tdo_bit = byte_sh_q[0];
    end

    // tdo moves on falling tck, driven only in shift states
    always @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_tdo <= 1'b0;
            o_tdo_oe <= 1'b0;
        end else if (port_on && tck_fall) begin
            o_tdo <= tdo_bit;
            o_tdo_oe <= (st_q == `JNPP_S_SDR) || (st_q == `JNPP_S_SIR);
        end else if (!port_on) begin
            o_tdo_oe <= 1'b0;
        end
    end

    // --------------------------------
    // core reset and time-out
    // --------------------------------
    // the chain bit is registered only once: a chip clock after tck, no
    // extra latch, so the hold takes effect at once
    reg [`JNPP_RST_TO_W-1:0] to_cnt_q;
    localparam [`JNPP_RST_TO_W-1:0] RST_TO_INIT = `JNPP_RST_TO_CYC;
    // power-on also runs the full time-out before the core is let go
    always @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            to_cnt_q <= RST_TO_INIT;
            o_core_reset <= 1'b1;
        end else if (hold_chain_q || !xrst_n_s) begin
            to_cnt_q <= RST_TO_INIT;
            o_core_reset <= 1'b1;
        end else if (to_cnt_q != 16'h0000) begin
            to_cnt_q <= to_cnt_q - 16'h0001;
            o_core_reset <= 1'b1;
        end else begin
            o_core_reset <= 1'b0;
        end
    end
endmodule

// *** jnpp_port_checker.sv ***
// concurrent checks on the ports of the nvm programming test port
`timescale 1ns/1ps
module jnpp_port_checker (
    input wire i_mclk,
    input wire i_rst,
    input wire i_tck,
    input wire i_tap_access_fuse,
    input wire i_tap_disable_set,
    input wire i_ext_reset_n,
    input wire o_tdo,
    input wire o_tdo_oe,
    input wire o_tap_disable_bit,
    input wire o_core_reset,
    input wire o_prog_enabled,
    input wire o_cmd_valid,
    input wire o_page_we,
    input wire o_page_re
);
    // ------------------------------------------------------------
    // properties, all in the chip clock domain
    // ------------------------------------------------------------
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // four cycles of margin cover the pin synchronisers
    a_fuse_off_quiet: assert property (!i_tap_access_fuse [*4] |-> !o_tdo_oe)
        else $error("tdo driven with access fuse off");
    a_dis_quiet: assert property (o_tap_disable_bit [*4] |-> !o_tdo_oe)
        else $error("tdo driven with disable bit set");
    a_dis_clears: assert property ((!i_ext_reset_n && !i_tap_disable_set) [*7] |-> !o_tap_disable_bit)
        else $error("disable bit not cleared under external reset");
    a_ext_core_rst: assert property (!i_ext_reset_n [*4] |-> o_core_reset)
        else $error("core not in reset with external reset low");
    // the release must follow a long stretch of reset, not a glitch
    a_rst_timeout: assert property ($fell(o_core_reset) |-> $past(o_core_reset, 60))
        else $error("core reset released before time-out");
    a_tdo_on_fall: assert property ($changed(o_tdo) && o_tdo_oe |-> !$past(i_tck, 2))
        else $error("tdo changed outside the tck low phase");
    a_cmd_locked: assert property (o_cmd_valid |-> o_prog_enabled)
        else $error("command applied while locked");
    a_fill_pulse: assert property (o_page_we |-> o_prog_enabled ##1 !o_page_we)
        else $error("page write bad");
    a_dump_pulse: assert property (o_page_re |-> o_prog_enabled ##1 !o_page_re)
        else $error("page read bad");
    a_rst_values: assert property ($fell(i_rst) |-> !o_prog_enabled && o_core_reset)
        else $error("bad state after power-on reset");
endmodule
bind jnpp_port jnpp_port_checker u_chk (.i_mclk, .i_rst, .i_tck, .i_tap_access_fuse,
    .i_tap_disable_set, .i_ext_reset_n, .o_tdo, .o_tdo_oe, .o_tap_disable_bit, .o_core_reset,
    .o_prog_enabled, .o_cmd_valid, .o_page_we, .o_page_re);

// *** jnpp_prog_model.sv ***
// behavioural external programmer driving the test port pins
`timescale 1ns/1ps
module jnpp_prog_model (
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi,
    input wire i_tdo
);
    // ------------------------------------------------------------
    // pin sequencing
    // ------------------------------------------------------------
    logic [1039:0] last;
    event got;
    // tck stands low between frames; odd start keeps it out of phase with mclk
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b0;
    end
    // tdo is sampled late in the high half so the falling-edge update has settled
    task automatic step(input logic ms, input logic di, output logic so);
        o_tms = ms;
        o_tdi = di;
        #80 o_tck = 1'b1;
        #80 so = i_tdo;
        o_tck = 1'b0;
    endtask
    task automatic tlr();
        logic s;
        #7;
        repeat (5) step(1'b1, 1'b0, s);
        step(1'b0, 1'b0, s);
    endtask
    // idle, select, capture, shift n bits, exit, update, back to idle
    task automatic scan(input logic ir, input logic [1039:0] din, input int n, input logic c);
        logic s;
        int i;
        step(1'b1, 1'b0, s);
        if (ir) step(1'b1, 1'b0, s);
        step(1'b0, 1'b0, s);
        step(1'b0, 1'b0, s);
        last = '0;
        for (i = 0; i < n; i++) begin
            step(i == n - 1, din[i], s);
            last[i] = s;
        end
        step(1'b1, 1'b0, s);
        step(1'b0, 1'b0, s);
        if (c) -> got;
    endtask
endmodule

// *** tb.sv ***
// self-checking bench for the nvm programming test port
`timescale 1ns/1ps
`include "jnpp_regs.vh"
module tb;
    // ------------------------------------------------------------
    // design, programmer and scoreboard
    // ------------------------------------------------------------
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic i_tap_access_fuse = 1'b0;
    logic i_tap_disable_set = 1'b0;
    logic i_ext_reset_n = 1'b1;
    logic [14:0] i_cmd_result = '0;
    logic [7:0] i_page_rdata = '0;
    wire i_tck, i_tms, i_tdi, o_tdo, o_tdo_oe, o_tap_disable_bit, o_core_reset;
    wire o_prog_enabled, o_cmd_valid, o_cmd_exec, o_page_we, o_page_re;
    wire [14:0] o_cmd;
    wire [6:0] o_page_addr;
    wire [7:0] o_page_wdata;
    int errors = 0;
    int checks_done = 0;
    int n_exec = 0;
    logic [1039:0] q_scan[$];
    logic [14:0] q_cmd[$];
    logic [14:0] q_we[$];
    jnpp_port dut (.i_mclk, .i_rst, .i_tck, .i_tms, .i_tdi, .i_tap_access_fuse,
        .i_tap_disable_set, .i_ext_reset_n, .i_cmd_result, .i_page_rdata, .o_tdo, .o_tdo_oe,
        .o_tap_disable_bit, .o_core_reset, .o_prog_enabled, .o_cmd, .o_cmd_valid, .o_cmd_exec,
        .o_page_we, .o_page_addr, .o_page_wdata, .o_page_re);
    jnpp_prog_model prog (.o_tck(i_tck), .o_tms(i_tms), .o_tdi(i_tdi), .i_tdo(o_tdo));
    always #10 i_mclk = ~i_mclk;
    task automatic chk(input string nm, input logic [1039:0] e, input logic [1039:0] s);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    // bounded wait for the core to leave reset
    task automatic wait_free();
        for (int k = 0; k < 200 && o_core_reset === 1'b1; k++) cyc(1);
    endtask
    // watchers take the oldest note whenever a result shows up
    always @(prog.got) chk("scan", q_scan.pop_front(), prog.last);
    // page memory stand-in answers each read with a pattern of its address
    always @(posedge i_mclk) begin
        if (o_cmd_valid) chk("cmd", q_cmd.pop_front(), o_cmd);
        if (o_page_we) chk("fill", q_we.pop_front(), {o_page_addr, o_page_wdata});
        if (o_cmd_exec) n_exec++;
        if (o_page_re) i_page_rdata <= {1'b0, o_page_addr} ^ 8'h5a;
    end
    initial begin
        #1_000_000;
        errors++;
        end_sim();
    end
    initial begin
        logic [1039:0] d;
        logic [1039:0] e;
        int k;
        void'($urandom(32'h1facad39));
        cyc(5);
        i_rst = 1'b0;
        cyc(3);
        chk("prog_rst", 1'b0, o_prog_enabled);
        // with the fuse unprogrammed an unlock attempt goes nowhere
        prog.tlr();
        prog.scan(1'b1, `JNPP_IR_UNLOCK, 4, 1'b0);
        prog.scan(1'b0, `JNPP_UNLOCK_SIG, 16, 1'b0);
        cyc(1);
        chk("fuse_off", 1'b0, o_prog_enabled);
        i_tap_access_fuse = 1'b1;
        i_tap_disable_set = 1'b1;
        cyc(1);
        i_tap_disable_set = 1'b0;
        i_ext_reset_n = 1'b0;
        cyc(2);
        chk("dis_hold", 1'b1, o_tap_disable_bit);
        cyc(6);
        chk("dis_clr", 1'b0, o_tap_disable_bit);
        chk("ext_core", 1'b1, o_core_reset);
        i_ext_reset_n = 1'b1;
        wait_free();
        // hold the core in reset before unlocking
        prog.tlr();
        prog.scan(1'b1, `JNPP_IR_CORE_HOLD, 4, 1'b0);
        prog.scan(1'b0, 1, 1, 1'b0);
        cyc(1);
        chk("hold", 1'b1, o_core_reset);
        prog.scan(1'b1, `JNPP_IR_UNLOCK, 4, 1'b0);
        for (k = 0; k < 3; k++) begin
            prog.scan(1'b0, `JNPP_UNLOCK_SIG ^ (16'h1 << $urandom_range(15)), 16, 1'b0);
            cyc(1);
            chk("bad_sig", 1'b0, o_prog_enabled);
        end
        prog.scan(1'b0, `JNPP_UNLOCK_SIG, 16, 1'b0);
        cyc(1);
        chk("unlock", 1'b1, o_prog_enabled);
        // three commands, the last the page-write poll
        prog.scan(1'b1, `JNPP_IR_CMD, 4, 1'b0);
        for (k = 0; k < 3; k++) begin
            d = (k == 2) ? 15'h3700 : $urandom;
            e = '0;
            e[14:0] = $urandom;
            cyc(1);
            i_cmd_result = e[14:0];
            q_cmd.push_back(d[14:0]);
            q_scan.push_back(e);
            prog.scan(1'b0, d, 15, 1'b1);
        end
        cyc(2);
        chk("exec", 3, n_exec);
        // fill: write address runs one ahead of the byte index
        for (k = 0; k < 128; k++) begin
            d[k*8 +: 8] = $urandom;
            q_we.push_back({7'(k + 1), d[k*8 +: 8]});
        end
        prog.scan(1'b1, `JNPP_IR_FILL, 4, 1'b0);
        prog.scan(1'b0, d, 1024, 1'b0);
        cyc(2);
        chk("fill_cnt", 0, q_we.size());
        // dump: leading dummy byte, then the page; random tdi must not matter
        e = '0;
        for (k = 0; k < 128; k++) e[k*8 + 8 +: 8] = k[7:0] ^ 8'h5a;
        q_scan.push_back(e);
        prog.scan(1'b1, `JNPP_IR_DUMP, 4, 1'b0);
        prog.scan(1'b0, d, 1032, 1'b1);
        // leave programming; a later command must be refused
        prog.scan(1'b1, `JNPP_IR_UNLOCK, 4, 1'b0);
        prog.scan(1'b0, `JNPP_UNLOCK_RST, 16, 1'b0);
        cyc(1);
        chk("relock", 1'b0, o_prog_enabled);
        prog.scan(1'b1, `JNPP_IR_CMD, 4, 1'b0);
        prog.scan(1'b0, 15'h1234, 15, 1'b0);
        prog.scan(1'b1, `JNPP_IR_CORE_HOLD, 4, 1'b0);
        prog.scan(1'b0, 0, 1, 1'b0);
        cyc(1);
        chk("timeout", 1'b1, o_core_reset);
        wait_free();
        chk("released", 1'b0, o_core_reset);
        chk("left", 0, q_scan.size() + q_cmd.size());
        end_sim();
    end
endmodule
